// *** design/bfs_pkg.sv ***
package bfs_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH_SMALL = 256;
  localparam int FIFO_DEPTH_LARGE = 1024;
  localparam int LONG_W = 36;
  localparam int WORD_MSB = 17;
  localparam int BYTE_MSB = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] OFFSET_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] LEVEL_OFS = 4'hC;

  // CTRL fields
  localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;
  localparam int CTRL_SIZE_LSB = 1;
  localparam int CTRL_SIZE_MSB = 2;
  // OFFSET fields
  localparam int OFS_AE_LSB = 0;
  localparam int OFS_AF_LSB = 16;
  // LEVEL fields
  localparam int LVL1_LSB = 0;
  localparam int LVL2_LSB = 16;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int FLAG_OFFSET_RESET = 8;

  // Bus sizing of port B
  typedef enum logic [1:0] {
    SIZE_LONG,
    SIZE_WORD,
    SIZE_BYTE
  } bfs_size_t;

  localparam logic [1:0] BEATS_WORD_LAST = 2'h1;
  localparam logic [1:0] BEATS_BYTE_LAST = 2'h3;

  // Sampled port pins
  typedef struct packed {
    logic cs_n;
    logic wr_sel;
    logic mb_sel;
    logic [LONG_W-1:0] data;
  } bfs_port_t;

endpackage : bfs_pkg

// *** design/bfs_sync.sv ***
`timescale 1ns/1ps

module bfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Second stage is the only reader of the first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : bfs_sync

// *** design/bfs_flag_mailbox.sv ***
`timescale 1ns/1ps

// Operation
// - FALL_THROUGH_MODE: port A input-ready rises after B frees
// - Standard: port A full flag releases after B read
// - FALL_THROUGH_MODE: port B input-ready rises after A frees
// - Standard: port B full flag releases after A read
// - Port B almost-empty rises after A write
// - Port A almost-empty rises after B write
// - Port A almost-full rises after B read
// - Port B almost-full rises after A read
// - Narrow B: ready/full move on final write
// - Narrow B: almost-full moves on final write
// - Narrow B: almost-empty moves on final read
// - Narrow B: freed location counts at final read
// - Narrow B: entry written only at final write
// - Narrow B: almost-full freed at final read
// - Thresholds sized for 256 or 1024 depth
// - Word size: mailbox one passes bits 0-17
// - Byte size: mailbox one passes bits 0-8
// - Word size: mailbox two passes bits 0-17
// - Byte size: mailbox two passes bits 0-8
// - FALL_THROUGH_MODE: output-ready within three B cycles
module bfs_flag_mailbox
  import bfs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_SMALL,
  parameter int PW = $clog2(DEPTH) + 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic porta_clock,
  input wire logic porta_chip_select_n,
  input wire logic porta_write_read_sel,
  input wire logic porta_mailbox_sel,
  input wire logic [LONG_W-1:0] porta_data_in,
  output logic [LONG_W-1:0] porta_data_out,
  output logic porta_data_oe,
  input wire logic portb_clock,
  input wire logic portb_chip_select_n,
  input wire logic portb_write_read_sel,
  input wire logic portb_mailbox_sel,
  input wire logic [LONG_W-1:0] portb_data_in,
  output logic [LONG_W-1:0] portb_data_out,
  output logic portb_data_oe,
  output logic porta_full_flag,
  output logic porta_input_ready,
  output logic portb_full_flag,
  output logic portb_input_ready,
  output logic porta_almost_empty,
  output logic portb_almost_empty,
  output logic porta_almost_full,
  output logic portb_almost_full,
  output logic porta_empty_flag,
  output logic porta_output_ready,
  output logic portb_empty_flag,
  output logic portb_output_ready,
  output logic first_mail_full,
  output logic second_mail_full
);

  localparam int SW = 2 + 2 * $bits(bfs_port_t);
  localparam logic [PW:0] DEPTH_X = (PW + 1)'(DEPTH);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  bfs_port_t pa_raw, pb_raw, pa, pb;
  logic porta_clock_s, portb_clock_s, porta_clock_d_q, portb_clock_d_q, a_edge, b_edge;
  logic [SW-1:0] sync_in, sync_out;

  assign pa_raw = '{porta_chip_select_n, porta_write_read_sel,
                    porta_mailbox_sel, porta_data_in};
  assign pb_raw = '{portb_chip_select_n, portb_write_read_sel,
                    portb_mailbox_sel, portb_data_in};
  assign sync_in = {porta_clock, portb_clock, pa_raw, pb_raw};

  // Clocks and controls share one two-stage synchronizer so they stay aligned
  bfs_sync #(.WIDTH(SW)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(sync_in),
    .sync_out(sync_out)
  );
  assign {porta_clock_s, portb_clock_s, pa, pb} = sync_out;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      porta_clock_d_q <= 1'b0;
      portb_clock_d_q <= 1'b0;
    end else if (clk_en) begin
      porta_clock_d_q <= porta_clock_s;
      portb_clock_d_q <= portb_clock_s;
    end
  end
  assign a_edge = porta_clock_s & ~porta_clock_d_q;
  assign b_edge = portb_clock_s & ~portb_clock_d_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic fall_through_mode_q;
  bfs_size_t size_q;
  logic [PW-1:0] ae_ofs_q, af_ofs_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic bus_req, bus_take;
  logic [31:0] status_w, level_w;

  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~wait_q;

  // One wait cycle, then the answer edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
    end else if (clk_en) begin
      wait_q <= ~(bus_req & wait_q);
    end
  end

  // Sizing must stay static while traffic runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fall_through_mode_q <= CTRL_RESET[CTRL_FALL_THROUGH_MODE_BIT];
      size_q <= bfs_size_t'(CTRL_RESET[CTRL_SIZE_MSB:CTRL_SIZE_LSB]);
      ae_ofs_q <= PW'(FLAG_OFFSET_RESET);
      af_ofs_q <= PW'(FLAG_OFFSET_RESET);
    end else if (clk_en && bus_take && avs_write) begin
      if (avs_address == CTRL_OFS) begin
        fall_through_mode_q <= avs_writedata[CTRL_FALL_THROUGH_MODE_BIT];
        size_q <= bfs_size_t'(avs_writedata[CTRL_SIZE_MSB:CTRL_SIZE_LSB]);
      end
      if (avs_address == OFFSET_OFS) begin
        ae_ofs_q <= avs_writedata[OFS_AE_LSB +: PW];
        af_ofs_q <= avs_writedata[OFS_AF_LSB +: PW];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (clk_en && bus_req && wait_q) begin
      unique case (avs_address)
        CTRL_OFS: rdata_q <= 32'({size_q, fall_through_mode_q});
        OFFSET_OFS: rdata_q <= (32'(af_ofs_q) << OFS_AF_LSB) | 32'(ae_ofs_q);
        STATUS_OFS: rdata_q <= status_w;
        LEVEL_OFS: rdata_q <= level_w;
        default: rdata_q <= '0;
      endcase
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ----------------------------------------------------------------
  // Long-word pointers and narrow beat counters
  // ----------------------------------------------------------------
  logic [PW-1:0] wr1_q, rd1_q, wr2_q, rd2_q;
  logic [PW-1:0] wr1_seen_q, rd1_seen_q, wr2_seen_q, rd2_seen_q;
  logic [PW-1:0] wr1_nx, rd1_nx, wr2_nx, rd2_nx;
  logic [PW-1:0] lvl1_a, lvl1_b, lvl2_a, lvl2_b;
  logic [1:0] wbeat_q, rbeat_q, beat_last;
  logic a_fifo, b_fifo, a_wr1, a_rd2, b_wr2, b_rd1, b_wr_last, b_rd_last;

  always_comb begin
    unique case (size_q)
      SIZE_WORD: beat_last = BEATS_WORD_LAST;
      SIZE_BYTE: beat_last = BEATS_BYTE_LAST;
      default: beat_last = '0;
    endcase
  end

  // Local view uses the copy from the previous cycle; an event in
  // the same cycle as the far edge waits one more far cycle
  assign lvl1_a = wr1_q - rd1_seen_q;
  assign lvl2_a = wr2_seen_q - rd2_q;
  assign lvl1_b = wr1_seen_q - rd1_q;
  assign lvl2_b = wr2_q - rd2_seen_q;

  assign a_fifo = a_edge & ~pa.cs_n & ~pa.mb_sel;
  assign b_fifo = b_edge & ~pb.cs_n & ~pb.mb_sel;
  assign a_wr1 = a_fifo & pa.wr_sel & (lvl1_a != PW'(DEPTH));
  assign a_rd2 = a_fifo & ~pa.wr_sel & (lvl2_a != '0);
  assign b_wr2 = b_fifo & ~pb.wr_sel & (lvl2_b != PW'(DEPTH));
  assign b_rd1 = b_fifo & pb.wr_sel & (lvl1_b != '0);
  assign b_wr_last = b_wr2 & (wbeat_q == beat_last);
  assign b_rd_last = b_rd1 & (rbeat_q == beat_last);

  assign wr1_nx = wr1_q + PW'(a_wr1);
  assign rd2_nx = rd2_q + PW'(a_rd2);
  assign wr2_nx = wr2_q + PW'(b_wr_last);
  assign rd1_nx = rd1_q + PW'(b_rd_last);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wbeat_q <= '0;
      rbeat_q <= '0;
    end else if (clk_en) begin
      if (b_wr2) begin
        wbeat_q <= b_wr_last ? 2'h0 : wbeat_q + 2'h1;
      end
      if (b_rd1) begin
        rbeat_q <= b_rd_last ? 2'h0 : rbeat_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr1_q <= '0;
      rd1_q <= '0;
      wr2_q <= '0;
      rd2_q <= '0;
    end else if (clk_en) begin
      wr1_q <= wr1_nx;
      rd1_q <= rd1_nx;
      wr2_q <= wr2_nx;
      rd2_q <= rd2_nx;
    end
  end

  // Staged copies toward the opposite port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr1_seen_q <= '0;
      rd1_seen_q <= '0;
      wr2_seen_q <= '0;
      rd2_seen_q <= '0;
    end else if (clk_en) begin
      wr1_seen_q <= wr1_q;
      rd1_seen_q <= rd1_q;
      wr2_seen_q <= wr2_q;
      rd2_seen_q <= rd2_q;
    end
  end

  // ----------------------------------------------------------------
  // Flags on port A edges
  // ----------------------------------------------------------------
  logic [PW-1:0] na1, na2, nb1, nb2;
  logic [1:0] ora_pipe_q, orb_pipe_q;
  logic space_a, space_b;

  assign na1 = wr1_nx - rd1_seen_q;
  assign na2 = wr2_seen_q - rd2_nx;
  assign nb1 = wr1_seen_q - rd1_nx;
  assign nb2 = wr2_nx - rd2_seen_q;
  assign space_a = na1 != PW'(DEPTH);
  assign space_b = nb2 != PW'(DEPTH);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      porta_full_flag <= 1'b0;
      porta_input_ready <= 1'b0;
      porta_almost_empty <= 1'b0;
      porta_almost_full <= 1'b0;
      porta_empty_flag <= 1'b0;
      porta_output_ready <= 1'b0;
      ora_pipe_q <= '0;
    end else if (clk_en && a_edge) begin
      porta_full_flag <= ~fall_through_mode_q & space_a;
      porta_input_ready <= fall_through_mode_q & space_a;
      porta_almost_empty <= na2 > ae_ofs_q;
      porta_almost_full <= ({1'b0, na1} + {1'b0, af_ofs_q}) <= DEPTH_X;
      porta_empty_flag <= ~fall_through_mode_q & (na2 != '0);
      ora_pipe_q <= {ora_pipe_q[0], na2 != '0};
      porta_output_ready <= fall_through_mode_q & ora_pipe_q[1] & (na2 != '0);
    end
  end

  // ----------------------------------------------------------------
  // Flags on port B edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      portb_full_flag <= 1'b0;
      portb_input_ready <= 1'b0;
      portb_almost_empty <= 1'b0;
      portb_almost_full <= 1'b0;
      portb_empty_flag <= 1'b0;
      portb_output_ready <= 1'b0;
      orb_pipe_q <= '0;
    end else if (clk_en && b_edge) begin
      portb_full_flag <= ~fall_through_mode_q & space_b;
      portb_input_ready <= fall_through_mode_q & space_b;
      portb_almost_empty <= nb1 > ae_ofs_q;
      portb_almost_full <= ({1'b0, nb2} + {1'b0, af_ofs_q}) <= DEPTH_X;
      portb_empty_flag <= ~fall_through_mode_q & (nb1 != '0);
      // Three B edges from first visibility to output-ready
      orb_pipe_q <= {orb_pipe_q[0], nb1 != '0};
      portb_output_ready <= fall_through_mode_q & orb_pipe_q[1] & (nb1 != '0);
    end
  end

  // ----------------------------------------------------------------
  // Mailboxes
  // ----------------------------------------------------------------
  logic [LONG_W-1:0] first_mailbox_q, second_mailbox_q, mask;
  logic a_mb_wr, a_mb_rd, b_mb_wr, b_mb_rd;

  // Unused upper lanes are driven low rather than left floating
  always_comb begin
    unique case (size_q)
      SIZE_WORD: mask = LONG_W'({(WORD_MSB + 1){1'b1}});
      SIZE_BYTE: mask = LONG_W'({(BYTE_MSB + 1){1'b1}});
      default: mask = '1;
    endcase
  end

  assign a_mb_wr = a_edge & ~pa.cs_n & pa.mb_sel & pa.wr_sel;
  assign a_mb_rd = a_edge & ~pa.cs_n & pa.mb_sel & ~pa.wr_sel;
  assign b_mb_wr = b_edge & ~pb.cs_n & pb.mb_sel & ~pb.wr_sel;
  assign b_mb_rd = b_edge & ~pb.cs_n & pb.mb_sel & pb.wr_sel;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_mailbox_q <= '0;
      second_mailbox_q <= '0;
    end else if (clk_en) begin
      if (a_mb_wr && !first_mail_full) begin
        first_mailbox_q <= pa.data & mask;
      end
      if (b_mb_wr && !second_mail_full) begin
        second_mailbox_q <= pb.data & mask;
      end
    end
  end

  // Set wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_mail_full <= 1'b0;
      second_mail_full <= 1'b0;
    end else if (clk_en) begin
      first_mail_full <= a_mb_wr | (first_mail_full & ~b_mb_rd);
      second_mail_full <= b_mb_wr | (second_mail_full & ~a_mb_rd);
    end
  end

  // FIFO storage lives elsewhere; only mail reaches the data pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      porta_data_out <= '0;
      porta_data_oe <= 1'b0;
      portb_data_out <= '0;
      portb_data_oe <= 1'b0;
    end else if (clk_en) begin
      if (a_edge) begin
        porta_data_oe <= ~pa.cs_n & ~pa.wr_sel;
        porta_data_out <= a_mb_rd ? second_mailbox_q : '0;
      end
      if (b_edge) begin
        portb_data_oe <= ~pb.cs_n & pb.wr_sel;
        portb_data_out <= b_mb_rd ? first_mailbox_q : '0;
      end
    end
  end

  assign status_w = 32'({second_mail_full, first_mail_full,
                         portb_output_ready, porta_output_ready,
                         portb_almost_full, porta_almost_full,
                         portb_almost_empty, porta_almost_empty,
                         portb_input_ready, porta_input_ready,
                         portb_full_flag, porta_full_flag});
  assign level_w = (32'(lvl2_a) << LVL2_LSB) | (32'(lvl1_b) << LVL1_LSB);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ira_release;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && a_edge && fall_through_mode_q && (na1 != PW'(DEPTH))) |=> porta_input_ready;
  endproperty
  a_ira_release: assert property (p_ira_release)
    else $error("input-ready A not raised");

  property p_ffa_release;
    @(posedge clk) disable iff (sys_rst)
    $changed(rd1_q) ##1 (clk_en && a_edge && !fall_through_mode_q) |=> porta_full_flag;
  endproperty
  a_ffa_release: assert property (p_ffa_release)
    else $error("full flag A not released after B read");

  property p_irb_release;
    @(posedge clk) disable iff (sys_rst)
    $changed(rd2_q) ##1 (clk_en && b_edge && fall_through_mode_q) |=> portb_input_ready;
  endproperty
  a_irb_release: assert property (p_irb_release)
    else $error("input-ready B not raised after A read");

  // Flags refresh only on their own port edge, so a mode written just
  // after reset is checked from the next B edge on
  property p_ffb_mode;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && b_edge && fall_through_mode_q) |=> !portb_full_flag;
  endproperty
  a_ffb_mode: assert property (p_ffb_mode)
    else $error("full flag driven in fall-through mode");

  property p_aeb_rise;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && b_edge && nb1 > ae_ofs_q) |=> portb_almost_empty;
  endproperty
  a_aeb_rise: assert property (p_aeb_rise)
    else $error("almost-empty B not raised");

  property p_afa_fall;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && a_edge && na1 == PW'(DEPTH)) |=> !porta_almost_full && !porta_full_flag;
  endproperty
  a_afa_fall: assert property (p_afa_fall)
    else $error("almost-full A high while full");

  property p_narrow_read;
    @(posedge clk) disable iff (sys_rst)
    $changed(rd1_q) |-> $past(rbeat_q) == $past(beat_last);
  endproperty
  a_narrow_read: assert property (p_narrow_read)
    else $error("read pointer moved before final beat");

  property p_narrow_write;
    @(posedge clk) disable iff (sys_rst)
    $changed(wr2_q) |-> $past(wbeat_q) == $past(beat_last);
  endproperty
  a_narrow_write: assert property (p_narrow_write)
    else $error("write pointer moved before final beat");

  property p_mail_set;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && a_mb_wr) |=> first_mail_full;
  endproperty
  a_mail_set: assert property (p_mail_set)
    else $error("mail flag one not set by write");

  property p_byte_mask;
    @(posedge clk) disable iff (sys_rst)
    (size_q == SIZE_BYTE && $stable(size_q)) ##1 $changed(first_mailbox_q)
      |-> first_mailbox_q[LONG_W-1:BYTE_MSB+1] == '0;
  endproperty
  a_byte_mask: assert property (p_byte_mask)
    else $error("mailbox one upper lanes not cleared");

  property p_bus_answer;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && bus_req && wait_q) |=> !wait_q ##1 wait_q;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle");

  c_fifo1_full: cover property (@(posedge clk) lvl1_a == PW'(DEPTH));
  c_narrow_write: cover property (@(posedge clk) b_wr_last && size_q == SIZE_BYTE);
  c_mail_round: cover property (@(posedge clk) first_mail_full ##[1:40] !first_mail_full);
  c_orb_up: cover property (@(posedge clk) $rose(portb_output_ready));

endmodule : bfs_flag_mailbox

// *** sim/bfs_host_model.sv ***
`timescale 1ns/1ps

// ----
// Synchronous host on one port
// ----
module bfs_host_model #(
  parameter int HALF = 4
) (
  input wire logic clk,
  output logic pclk,
  output logic cs_n,
  output logic wr_sel,
  output logic mb_sel,
  output logic [35:0] data
);
  int cnt;

  initial begin
    cnt = 0;
    pclk = 1'b0;
    cs_n = 1'b1;
    wr_sel = 1'b0;
    mb_sel = 1'b0;
    data = 36'h0;
  end

  // Free running, derived from clk but with its own period
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      pclk <= ~pclk;
  end

  // Pins move at the falling port edge: half a period of setup
  task automatic op(input logic w, input logic m, input logic [35:0] d);
    @(negedge pclk);
    cs_n <= 1'b0;
    wr_sel <= w;
    mb_sel <= m;
    data <= d;
    @(posedge pclk);
  endtask : op

  // Released bus shows the inverse, never a stale copy
  task automatic idle();
    @(negedge pclk);
    cs_n <= 1'b1;
    data <= ~data;
  endtask : idle
endmodule : bfs_host_model

// *** sim/tb_bidir_fifo_flag_sync_mailbox.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((e) !== (g)) begin \
    failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end

module tb_bidir_fifo_flag_sync_mailbox import bfs_pkg::*;;
  typedef struct {
    string nm;
    logic [35:0] mask;
    logic [35:0] val;
  } bfs_exp_t;
  localparam int D = FIFO_DEPTH_SMALL;
  logic clk, sys_rst, avs_read, avs_write;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pa_clk, pa_cs_n, pa_wr, pa_mb, pa_oe;
  wire pb_clk, pb_cs_n, pb_wr, pb_mb, pb_oe;
  wire ef_a, ef_b;
  logic clk_en;
  wire [LONG_W-1:0] pa_din, pa_dout, pb_din, pb_dout;
  wire [11:0] fl;
  int failures, check_count;
  bfs_exp_t qr[$], qa[$], qb[$];
  logic oa_q = 1'b0;
  logic ob_q = 1'b0;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----
  // Hosts and design
  // ----
  bfs_host_model #(.HALF(4)) ha (.clk(clk), .pclk(pa_clk),
    .cs_n(pa_cs_n), .wr_sel(pa_wr), .mb_sel(pa_mb), .data(pa_din));
  bfs_host_model #(.HALF(5)) hb (.clk(clk), .pclk(pb_clk),
    .cs_n(pb_cs_n), .wr_sel(pb_wr), .mb_sel(pb_mb), .data(pb_din));
  bfs_flag_mailbox #(.DEPTH(D)) uut (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .porta_clock(pa_clk), .porta_chip_select_n(pa_cs_n),
    .porta_write_read_sel(pa_wr), .porta_mailbox_sel(pa_mb),
    .porta_data_in(pa_din), .porta_data_out(pa_dout),
    .porta_data_oe(pa_oe), .portb_clock(pb_clk),
    .portb_chip_select_n(pb_cs_n), .portb_write_read_sel(pb_wr),
    .portb_mailbox_sel(pb_mb), .portb_data_in(pb_din),
    .portb_data_out(pb_dout), .portb_data_oe(pb_oe),
    .porta_full_flag(fl[0]), .portb_full_flag(fl[1]),
    .porta_input_ready(fl[2]), .portb_input_ready(fl[3]),
    .porta_almost_empty(fl[4]), .portb_almost_empty(fl[5]),
    .porta_almost_full(fl[6]), .portb_almost_full(fl[7]),
    .porta_output_ready(fl[8]), .portb_output_ready(fl[9]),
    .first_mail_full(fl[10]), .second_mail_full(fl[11]),
    .porta_empty_flag(ef_a), .portb_empty_flag(ef_b));

  // ----
  // Tasks
  // ----
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic bus(input logic r, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    avs_read <= r;
    avs_write <= ~r;
    avs_address <= a;
    avs_writedata <= wd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input string n, input logic [ADDR_W-1:0] a,
                    input logic [35:0] m, input logic [35:0] v);
    qr.push_back('{n, m, v});
    bus(1'b1, a, 32'h0);
  endtask : rd

  // Settle covers four cycles of the slower port
  task automatic st(input logic [35:0] m, input logic [35:0] v);
    repeat (40) @(posedge clk);
    rd("status", STATUS_OFS, m, v);
  endtask : st

  task automatic lv(input int d, input int n);
    rd("level", LEVEL_OFS, 36'hFFFF << (d * 16), 36'(n) << (d * 16));
  endtask : lv

  task automatic ops(input bit b, input logic w, input logic m,
                     input int n, input logic [35:0] x);
    repeat (n) begin
      if (b)
        hb.op(w, m, x);
      else
        ha.op(w, m, x);
    end
    if (b)
      hb.idle();
    else
      ha.idle();
  endtask : ops

  task automatic rst(input logic [31:0] c);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, CTRL_OFS, c);
  endtask : rst

  // ----
  // Result watcher
  // ----
  always @(posedge clk) begin
    bfs_exp_t e;
    if (avs_read && avs_waitrequest === 1'b0 && qr.size() > 0) begin
      e = qr.pop_front();
      `CHK(e.nm, e.val & e.mask, {4'h0, avs_readdata} & e.mask)
      if (e.nm == "status")
        `CHK("pins", e.val[11:0] & e.mask[11:0], fl & e.mask[11:0])
    end
    if (pb_oe === 1'b1 && !ob_q && qb.size() > 0) begin
      e = qb.pop_front();
      `CHK(e.nm, e.val & e.mask, pb_dout & e.mask)
    end
    if (pa_oe === 1'b1 && !oa_q && qa.size() > 0) begin
      e = qa.pop_front();
      `CHK(e.nm, e.val & e.mask, pa_dout & e.mask)
    end
    ob_q <= pb_oe === 1'b1;
    oa_q <= pa_oe === 1'b1;
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    test_done();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    logic [35:0] fb, mk, x;
    int bt;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    void'($urandom(32'hFB8E));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd("ctrl", CTRL_OFS, 36'hFFFFFFFF, {4'h0, CTRL_RESET});
    rd("offset", OFFSET_OFS, 36'hFFFFFFFF,
       {4'h0, 16'(FLAG_OFFSET_RESET), 16'(FLAG_OFFSET_RESET)});
    bus(1'b0, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, STATUS_OFS, 32'hFFFF_FFFF);
    rd("unmapped", 4'h2, 36'hFFFFFFFF, 36'h0);
    st(36'hFFF, 36'h0C3);
    `CHK("empty", 2'b00, {ef_b, ef_a})
    // Long bus, both timing modes, both directions
    for (int m = 0; m < 2; m++) begin
      rst(32'(m));
      for (int d = 0; d < 2; d++) begin
        fb = 36'h1 << (2 * m + d);
        ops(d, !d, 1'b0, 9, 36'(m + d));
        st(36'h1 << (5 - d), 36'h1 << (5 - d));
        lv(d, 9);
        if (m)
          st(36'h1 << (9 - d), 36'h1 << (9 - d));
        ops(d, !d, 1'b0, D - 16, 36'({$urandom, $urandom}));
        st(36'h1 << (6 + d), 36'h0);
        ops(d, !d, 1'b0, 7, 36'h5);
        st(fb, 36'h0);
        ops(!d, !d, 1'b0, 1, 36'h0);
        st(fb, fb);
        lv(d, D - 1);
        ops(!d, !d, 1'b0, 7, 36'h0);
        st(36'h1 << (6 + d), 36'h1 << (6 + d));
      end
    end
    // Port B long, word and byte
    for (int s = 0; s < 3; s++) begin
      bt = 1 << s;
      mk = (s == 0) ? '1 : (s == 1) ? 36'h3_FFFF : 36'h1FF;
      rst(32'(s) << CTRL_SIZE_LSB);
      ops(0, 1'b1, 1'b0, 9, 36'h9);
      ops(1, 1'b1, 1'b0, bt - 1, 36'h0);
      lv(0, 9);
      st(36'h20, 36'h20);
      ops(1, 1'b1, 1'b0, 1, 36'h0);
      lv(0, 8);
      st(36'h20, 36'h0);
      ops(1, 1'b0, 1'b0, bt - 1, 36'h7);
      lv(1, 0);
      ops(1, 1'b0, 1'b0, 1, 36'h7);
      lv(1, 1);
      repeat (40) @(posedge clk);
      `CHK("empty", 2'b11, {ef_b, ef_a})
      x = 36'({$urandom, $urandom});
      ops(0, 1'b1, 1'b1, 1, x);
      st(36'h400, 36'h400);
      qb.push_back('{"mail_one", mk, x});
      ops(1, 1'b1, 1'b1, 1, ~x);
      st(36'h400, 36'h0);
      x = 36'({$urandom, $urandom});
      ops(1, 1'b0, 1'b1, 1, x);
      st(36'h800, 36'h800);
      qa.push_back('{"mail_two", mk, x});
      ops(0, 1'b0, 1'b1, 1, ~x);
      st(36'h800, 36'h0);
    end
    // Frozen block misses a port write entirely
    clk_en <= 1'b0;
    ops(0, 1'b1, 1'b0, 1, 36'h1);
    clk_en <= 1'b1;
    lv(0, 8);
    test_done();
  end
endmodule : tb_bidir_fifo_flag_sync_mailbox
